// [logic/lock_defines.svh]
// offsets, reset values and fixed codes of the access-control block
`ifndef LOCK_DEFINES_SVH
`define LOCK_DEFINES_SVH
`define OFS_KEY_LEVEL     6'h00
`define OFS_SERIAL_GUARD  6'h01
`define OFS_LOADER_GUARD  6'h02
`define OFS_VIEW_GATE     6'h03
`define OFS_FIRST_PRI     6'h04
`define OFS_SECOND_PRI    6'h05
`define OFS_FIRST_CONF    6'h06
`define OFS_SECOND_CONF   6'h07
`define OFS_USER_TIER     6'h08
`define OFS_SLOT_BASE     6'h09
`define OFS_SLOT_LAST     6'h10
`define OFS_STATUS        6'h11
`define RST_KEY_LEVEL     2'h0
`define RST_GUARD         1'h0
`define RST_VIEW_GATE     4'h0
`define RST_SECRET        16'h0000
`define RST_USER_TIER     2'h0
`define RST_SLOT          8'h00
`define VIEW_GATE_OPEN    4'h5
`define TIER_HIGH         2'h2
`define SLOT_EMPTY        8'h00
`define SLOT_COUNT        8
`endif

// [logic/lock_pkg.sv]
// types shared by the access-control block
package lock_pkg;
  typedef enum logic [1:0] {SRC_KEYPAD, SRC_SERIAL, SRC_LOADER} src_t;
  typedef enum logic [3:0] {
    CL_SETUP, CL_MODE, CL_EVENT, CL_OPDISP, CL_TARGET, CL_SLOT, CL_LOCK,
    CL_MANUAL, CL_MODE_KEY, CL_GATE, CL_PRIMARY, CL_CONFIRM
  } pclass_t;
  typedef enum logic {WB_IDLE, WB_ACK} wb_state_t;
  typedef struct packed {
    logic       valid;
    src_t       src;
    pclass_t    pclass;
    logic [1:0] tier_code;
    logic [7:0] param_id;
    logic       exempt;
  } query_t;
  typedef struct packed {
    logic valid;
    logic show;
    logic allow;
  } verdict_t;
endpackage : lock_pkg

// [logic/lock_access_control.sv]
// access-control logic: keypad lock, link guards, password lock, tiers
// Functional notes
// - keypad lock level 0..3 progressively narrows which classes keys may change.
// - serial guard 1 refuses link reads/writes except the exempt set.
// - loader guard 1 refuses loader reads/writes except the exempt set.
// - exempt parameters stay reachable over serial and loader despite guards.
// - keypad lock alone keeps restricted parameters visible but unchangeable.
// - under password lock, keypad-restricted parameters are neither shown nor changed.
// - password lock blocks changes to keypad lock and both guards.
// - view gate 0..15 clears at power-up; only 5 exposes password entries.
// - four 16-bit password entries, each resetting to 0000.
// - primary entries usable only with gate 5 and both pairs matching.
// - confirmation entries usable whenever gate is 5.
// - writing a primary entry copies it into its confirmation entry.
// - any pair mismatch means password lock: primaries hidden, lock settings frozen.
// - in password lock, hide everything the keypad level makes unchangeable.
// - slot-registered parameters display as if the highest tier were chosen.
// - eight user-function slots, each holding one parameter reference.
// - tier code 0 all tiers, 1 standard and high, 2 high only.
// - user tier setting simple/standard/high, reset 0.
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lock_defines.svh"
module lock_access_control
  import lock_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire query_t      query_i,
  output verdict_t         verdict_o,
  output logic             pw_lock_o
);

  logic [1:0]  key_level_reg;
  logic        serial_guard_reg;
  logic        loader_guard_reg;
  logic [3:0]  view_gate_reg;
  logic [15:0] secret_first_primary;
  logic [15:0] secret_second_primary;
  logic [15:0] secret_first_confirm;
  logic [15:0] secret_second_confirm;
  logic [1:0]  user_tier_setting;
  logic [7:0]  user_function_slot [`SLOT_COUNT];
  wb_state_t   wb_state_reg;
  logic [31:0] rd_next;
  verdict_t    verdict_next;
  logic        pw_match;
  logic        gate_open;
  logic        wr_go;
  logic [5:0]  widx;

  // masks a 16-bit field by the two low byte lanes
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
    merge16 = {sel[1] ? new_v[15:8] : old_v[15:8],
               sel[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction : merge16

  // keypad classes the current level no longer allows
  function automatic logic key_restricted(input logic [1:0] lvl, input pclass_t cl);
    logic keep;
    keep = 1'b0;
    case (cl)
      CL_SLOT, CL_LOCK, CL_MANUAL, CL_MODE_KEY,
      CL_GATE, CL_PRIMARY, CL_CONFIRM: keep = 1'b1;
      CL_OPDISP, CL_TARGET:            keep = (lvl <= 2'h2);
      CL_MODE, CL_EVENT:               keep = (lvl <= 2'h1);
      default:                         keep = (lvl == 2'h0);
    endcase
    key_restricted = !keep;
  endfunction : key_restricted

  // parameter present in any filled slot
  function automatic logic slot_hit(input logic [7:0] id);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `SLOT_COUNT; i++) begin
      if (user_function_slot[i] == id && id != `SLOT_EMPTY) begin
        hit = 1'b1;
      end
    end
    slot_hit = hit;
  endfunction : slot_hit

  assign pw_match  = (secret_first_primary == secret_first_confirm) &&
                     (secret_second_primary == secret_second_confirm);
  assign gate_open = (view_gate_reg == `VIEW_GATE_OPEN);
  assign wr_go     = ce_i && wb_cyc_i && wb_stb_i && wb_we_i && (wb_state_reg == WB_IDLE);
  assign widx      = wb_adr_i[7:2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_state_reg <= WB_IDLE;
    end else if (ce_i) begin
      case (wb_state_reg)
        WB_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            wb_state_reg <= WB_ACK;
          end
        end
        WB_ACK:  wb_state_reg <= WB_IDLE;
        default: wb_state_reg <= WB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && (wb_state_reg == WB_IDLE);
      wb_dat_o <= rd_next;
    end
  end

  // lock settings frozen while the pairs mismatch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_level_reg    <= `RST_KEY_LEVEL;
      serial_guard_reg <= `RST_GUARD;
      loader_guard_reg <= `RST_GUARD;
    end else if (wr_go && pw_match && wb_sel_i[0]) begin
      if (widx == `OFS_KEY_LEVEL) key_level_reg <= wb_dat_i[1:0];
      if (widx == `OFS_SERIAL_GUARD) serial_guard_reg <= wb_dat_i[0];
      if (widx == `OFS_LOADER_GUARD) loader_guard_reg <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      view_gate_reg <= `RST_VIEW_GATE;
    end else if (wr_go && wb_sel_i[0] && widx == `OFS_VIEW_GATE) begin
      view_gate_reg <= wb_dat_i[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      secret_first_primary  <= `RST_SECRET;
      secret_second_primary <= `RST_SECRET;
      secret_first_confirm  <= `RST_SECRET;
      secret_second_confirm <= `RST_SECRET;
    end else if (wr_go && gate_open) begin
      // primaries need an open gate and matching pairs
      if (widx == `OFS_FIRST_PRI && pw_match) begin
        secret_first_primary <= merge16(secret_first_primary, wb_dat_i, wb_sel_i);
        secret_first_confirm <= merge16(secret_first_primary, wb_dat_i, wb_sel_i);
      end
      if (widx == `OFS_SECOND_PRI && pw_match) begin
        secret_second_primary <= merge16(secret_second_primary, wb_dat_i, wb_sel_i);
        secret_second_confirm <= merge16(secret_second_primary, wb_dat_i, wb_sel_i);
      end
      if (widx == `OFS_FIRST_CONF) begin
        secret_first_confirm <= merge16(secret_first_confirm, wb_dat_i, wb_sel_i);
      end
      if (widx == `OFS_SECOND_CONF) begin
        secret_second_confirm <= merge16(secret_second_confirm, wb_dat_i, wb_sel_i);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      user_tier_setting <= `RST_USER_TIER;
      for (int i = 0; i < `SLOT_COUNT; i++) begin
        user_function_slot[i] <= `RST_SLOT;
      end
    end else if (wr_go && wb_sel_i[0]) begin
      if (widx == `OFS_USER_TIER && wb_dat_i[1:0] <= `TIER_HIGH) begin
        user_tier_setting <= wb_dat_i[1:0];
      end
      if (widx >= `OFS_SLOT_BASE && widx <= `OFS_SLOT_LAST) begin
        user_function_slot[3'(widx - `OFS_SLOT_BASE)] <= wb_dat_i[7:0];
      end
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    case (widx)
      `OFS_KEY_LEVEL:    rd_next[1:0] = key_level_reg;
      `OFS_SERIAL_GUARD: rd_next[0] = serial_guard_reg;
      `OFS_LOADER_GUARD: rd_next[0] = loader_guard_reg;
      `OFS_VIEW_GATE:    rd_next[3:0] = view_gate_reg;
      // primaries hidden unless matched and gate open
      `OFS_FIRST_PRI:    rd_next[15:0] = (gate_open && pw_match) ? secret_first_primary : 16'h0;
      `OFS_SECOND_PRI:   rd_next[15:0] = (gate_open && pw_match) ? secret_second_primary : 16'h0;
      `OFS_FIRST_CONF:   rd_next[15:0] = gate_open ? secret_first_confirm : 16'h0;
      `OFS_SECOND_CONF:  rd_next[15:0] = gate_open ? secret_second_confirm : 16'h0;
      `OFS_USER_TIER:    rd_next[1:0] = user_tier_setting;
      `OFS_STATUS:       rd_next[0] = !pw_match;
      default: begin
        if (widx >= `OFS_SLOT_BASE && widx <= `OFS_SLOT_LAST) begin
          rd_next[7:0] = user_function_slot[3'(widx - `OFS_SLOT_BASE)];
        end
      end
    endcase
  end

  // per-query verdict
  always_comb begin
    logic       restr;
    logic       tier_ok;
    logic       pw_ok_show;
    logic       pw_ok_set;
    logic       guard;
    logic [1:0] eff_tier;
    restr      = key_restricted(key_level_reg, query_i.pclass);
    // slot parameters use the highest tier
    eff_tier   = slot_hit(query_i.param_id) ? `TIER_HIGH : user_tier_setting;
    tier_ok    = (query_i.tier_code <= eff_tier);
    pw_ok_show = 1'b1;
    if (query_i.pclass == CL_PRIMARY) pw_ok_show = gate_open && pw_match;
    if (query_i.pclass == CL_CONFIRM) pw_ok_show = gate_open;
    // lock class frozen under password lock
    pw_ok_set  = pw_ok_show && !(query_i.pclass == CL_LOCK && !pw_match);
    guard      = (query_i.src == SRC_SERIAL) ? serial_guard_reg : loader_guard_reg;
    verdict_next.valid = query_i.valid;
    if (query_i.src == SRC_KEYPAD) begin
      // restricted items vanish under password lock
      verdict_next.show  = tier_ok && pw_ok_show && !(restr && !pw_match);
      verdict_next.allow = verdict_next.show && pw_ok_set && !restr;
    end else begin
      // guards with the exempt set, no keypad lock here
      verdict_next.show  = (!guard || query_i.exempt) && pw_ok_show;
      verdict_next.allow = verdict_next.show && pw_ok_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      verdict_o <= '0;
      pw_lock_o <= 1'b0;
    end else if (ce_i) begin
      verdict_o <= verdict_next;
      pw_lock_o <= !pw_match;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_gate_reset;
    disable iff (1'b0) rst_i |=> view_gate_reg == 4'h0;
  endproperty
  a_gate_reset: assert property (p_gate_reset) else $error("gate not cleared by reset");

  property p_copy;
    wr_go && gate_open && pw_match && widx == `OFS_FIRST_PRI && wb_sel_i[1:0] == 2'h3
      |=> secret_first_confirm == $past(wb_dat_i[15:0]) && pw_match;
  endproperty
  a_copy: assert property (p_copy) else $error("primary not copied to confirm");

  property p_lock_frozen;
    !pw_match && wr_go |=> $stable(key_level_reg) && $stable(serial_guard_reg);
  endproperty
  a_lock_frozen: assert property (p_lock_frozen) else $error("lock setting changed");

  property p_serial_guard;
    ce_i && query_i.src == SRC_SERIAL && serial_guard_reg && !query_i.exempt
      |=> !verdict_o.show && !verdict_o.allow;
  endproperty
  a_serial_guard: assert property (p_serial_guard) else $error("guarded serial access");

  property p_exempt;
    ce_i && query_i.src == SRC_LOADER && query_i.exempt && query_i.pclass == CL_MODE
      |=> verdict_o.show && verdict_o.allow;
  endproperty
  a_exempt: assert property (p_exempt) else $error("exempt access refused");

  property p_level3;
    ce_i && query_i.src == SRC_KEYPAD && key_level_reg == 2'h3 && query_i.pclass == CL_TARGET
      |=> !verdict_o.allow;
  endproperty
  a_level3: assert property (p_level3) else $error("target changeable at level 3");

  property p_hide;
    ce_i && query_i.src == SRC_KEYPAD && !pw_match && key_level_reg == 2'h1 &&
      query_i.pclass == CL_SETUP |=> !verdict_o.show && pw_lock_o;
  endproperty
  a_hide: assert property (p_hide) else $error("restricted item shown in password lock");

  property p_slot_tier;
    ce_i && query_i.src == SRC_KEYPAD && slot_hit(query_i.param_id) &&
      query_i.tier_code == 2'h2 && query_i.pclass == CL_SETUP && key_level_reg == 2'h0
      |=> verdict_o.show;
  endproperty
  a_slot_tier: assert property (p_slot_tier) else $error("slot item hidden by tier");

  property p_primary_gate;
    ce_i && query_i.pclass == CL_PRIMARY && view_gate_reg != 4'h5 |=> !verdict_o.show;
  endproperty
  a_primary_gate: assert property (p_primary_gate) else $error("primary shown with gate shut");

  property p_confirm_gate;
    ce_i && query_i.src == SRC_KEYPAD && query_i.pclass == CL_CONFIRM &&
      query_i.tier_code == 2'h0 && view_gate_reg == 4'h5 |=> verdict_o.show && verdict_o.allow;
  endproperty
  a_confirm_gate: assert property (p_confirm_gate) else $error("confirm refused with gate open");

  property p_status;
    ce_i && !pw_match |=> pw_lock_o;
  endproperty
  a_status: assert property (p_status) else $error("lock status not raised");

  property p_tier;
    ce_i && query_i.src == SRC_KEYPAD && !slot_hit(query_i.param_id) &&
      query_i.tier_code > user_tier_setting |=> !verdict_o.show;
  endproperty
  a_tier: assert property (p_tier) else $error("item shown above user tier");

  property p_primary_write;
    wr_go && widx == `OFS_FIRST_PRI && !gate_open |=> $stable(secret_first_primary);
  endproperty
  a_primary_write: assert property (p_primary_write) else $error("primary written with gate shut");

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

endmodule : lock_access_control
`default_nettype wire

// [testbench/query_source.sv]
// far-side requester: keypad, serial host and loader posing queries
`timescale 1ns/1ps
`default_nettype none
module query_source
  import lock_pkg::*;
(
  input  wire logic   clk_i,
  input  wire query_t req_i,
  output query_t      query_o
);
  // a request leaves the operator one edge after it is posed
  always_ff @(posedge clk_i) begin
    query_o <= req_i;
  end
endmodule : query_source
`default_nettype wire

// [testbench/lock_access_control_test.sv]
// self-checking bench for the access-control block
`timescale 1ns/1ps
`default_nettype none
module lock_access_control_test
  import lock_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        pwl;
  query_t      req = '0;
  query_t      q;
  verdict_t    vd;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [32:0] acc_q[$];
  logic [1:0]  vd_q[$];
  logic [31:0] v;

  always #20 clk = ~clk;

  query_source u_src (.clk_i(clk), .req_i(req), .query_o(q));
  lock_access_control u_dut (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .query_i(q), .verdict_o(vd), .pw_lock_o(pwl));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic cmp_data(input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD rdata expected %h seen %h", e, s);
    end
  endtask : cmp_data

  task automatic cmp_vd(input logic [1:0] e, input logic [1:0] s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD verdict expected %b seen %b", e, s);
    end
  endtask : cmp_vd

  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [5:0] ix, input logic [31:0] d);
    acc_q.push_back({~w, d});
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic ask(input src_t s, input pclass_t c, input logic [1:0] tc,
                     input logic [7:0] id, input logic ex, input logic [1:0] e);
    vd_q.push_back(e);
    req <= '{1'b1, s, c, tc, id, ex};
    @(posedge clk);
    req.valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : ask

  always @(negedge clk) begin
    logic [32:0] e;
    if (ack === 1'b1 && acc_q.size() > 0) begin
      e = acc_q.pop_front();
      if (e[32]) cmp_data(e[31:0], rdat);
    end
    if (vd.valid === 1'b1 && vd_q.size() > 0) cmp_vd(vd_q.pop_front(), {vd.show, vd.allow});
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(32'h2423aa6d));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 18; i++) bus(1'b0, 6'(i), 32'h0);
    bus(1'b0, 6'h2a, 32'h0);
    for (int l = 0; l < 4; l++) begin
      bus(1'b1, 6'h00, 32'(l));
      ask(SRC_KEYPAD, CL_MODE, 2'h0, 8'h01, 1'b0, {1'b1, l < 2});
      ask(SRC_KEYPAD, CL_OPDISP, 2'h0, 8'h01, 1'b0, {1'b1, l < 3});
      ask(SRC_KEYPAD, CL_SLOT, 2'h0, 8'h01, 1'b0, 2'b11);
      ask(SRC_KEYPAD, CL_SETUP, 2'h0, 8'h01, 1'b0, {1'b1, l == 0});
    end
    ask(SRC_SERIAL, CL_TARGET, 2'h2, 8'h01, 1'b0, 2'b11);
    bus(1'b1, 6'h01, 32'h1);
    ask(SRC_SERIAL, CL_SETUP, 2'h0, 8'h01, 1'b0, 2'b00);
    ask(SRC_SERIAL, CL_OPDISP, 2'h0, 8'h01, 1'b1, 2'b11);
    ask(SRC_LOADER, CL_SETUP, 2'h0, 8'h01, 1'b0, 2'b11);
    bus(1'b1, 6'h02, 32'h1);
    ask(SRC_LOADER, CL_SETUP, 2'h0, 8'h01, 1'b0, 2'b00);
    ask(SRC_LOADER, CL_MODE, 2'h0, 8'h01, 1'b1, 2'b11);
    v = $urandom & 32'hffff;
    bus(1'b1, 6'h03, 32'h5);
    bus(1'b1, 6'h04, v);
    bus(1'b0, 6'h06, v);
    bus(1'b0, 6'h04, v);
    bus(1'b1, 6'h06, v ^ 32'h1);
    bus(1'b0, 6'h11, 32'h1);
    bus(1'b0, 6'h04, 32'h0);
    bus(1'b0, 6'h06, v ^ 32'h1);
    ask(SRC_KEYPAD, CL_CONFIRM, 2'h0, 8'h01, 1'b0, 2'b11);
    bus(1'b1, 6'h00, 32'h0);
    bus(1'b1, 6'h01, 32'h0);
    bus(1'b0, 6'h00, 32'h3);
    bus(1'b0, 6'h01, 32'h1);
    ask(SRC_KEYPAD, CL_TARGET, 2'h0, 8'h01, 1'b0, 2'b00);
    ask(SRC_KEYPAD, CL_LOCK, 2'h0, 8'h01, 1'b0, 2'b10);
    bus(1'b1, 6'h04, 32'h0);
    bus(1'b0, 6'h06, v ^ 32'h1);
    bus(1'b1, 6'h06, v);
    bus(1'b0, 6'h11, 32'h0);
    bus(1'b1, 6'h00, 32'h0);
    bus(1'b0, 6'h00, 32'h0);
    bus(1'b1, 6'h03, 32'h4);
    bus(1'b0, 6'h06, 32'h0);
    ask(SRC_KEYPAD, CL_PRIMARY, 2'h0, 8'h01, 1'b0, 2'b00);
    bus(1'b1, 6'h04, 32'h1234);
    bus(1'b0, 6'h11, 32'h0);
    ask(SRC_KEYPAD, CL_TARGET, 2'h2, 8'h33, 1'b0, 2'b00);
    ask(SRC_KEYPAD, CL_TARGET, 2'h0, 8'h33, 1'b0, 2'b11);
    bus(1'b1, 6'h08, 32'h3);
    bus(1'b0, 6'h08, 32'h0);
    bus(1'b1, 6'h08, 32'h1);
    ask(SRC_KEYPAD, CL_TARGET, 2'h1, 8'h44, 1'b0, 2'b11);
    ask(SRC_KEYPAD, CL_TARGET, 2'h2, 8'h44, 1'b0, 2'b00);
    bus(1'b1, 6'h0b, 32'h33);
    ask(SRC_KEYPAD, CL_TARGET, 2'h2, 8'h33, 1'b0, 2'b11);
    ask(SRC_KEYPAD, CL_SETUP, 2'h2, 8'h33, 1'b0, 2'b11);
    for (int i = 9; i < 17; i++) begin
      v = ($urandom & 32'hff) | 32'h1;
      bus(1'b1, 6'(i), v);
      bus(1'b0, 6'(i), v);
    end
    cmp_data(32'h0, 32'(vd_q.size() + acc_q.size()));
    end_sim();
  end
endmodule : lock_access_control_test
`default_nettype wire
